// ===== bmmd_decoder.sv
// bmmd_decoder: program counter, program address wrap and banked data decode.
// assumes the processor core sits on the same clock and issues one data
// access per cycle; special-function registers live outside this block.
`timescale 1ns/1ns
module bmmd_decoder
  import bmmd_pkg::*;
(
  // clock and reset
  input  wire logic                 clk_sys,
  input  wire logic                 rst_b,
  // program counter control from the core
  input  wire logic                 pcStep,
  input  wire logic                 pcLoad,
  input  wire logic [PC_W-1:0]      pcLoadValue,
  input  wire logic                 intEntry,
  output logic      [PC_W-1:0]      pcValue,
  output logic      [PM_ADDR_W-1:0] fetchAddr,
  output logic                      fetchHighEnd,
  // program memory data read
  input  wire logic                 pmReadReq,
  input  wire logic [PC_W-1:0]      pmReadAddr,
  output logic      [PM_ADDR_W-1:0] pmReadPhys,
  output logic                      pmReadHighEnd,
  // data access from the core, offset of the instruction
  input  wire logic                 dataReq,
  input  wire logic                 dataWe,
  input  wire logic [OFFS_W-1:0]    dataOffset,
  input  wire logic [7:0]           dataWdata,
  output logic      [7:0]           dataRdata,
  output logic                      dataRvalid,
  // special-function register port
  output logic                      sfrReq,
  output logic                      sfrWe,
  output logic      [DATA_ADDR_W-1:0] sfrAddr,
  output logic      [7:0]           sfrWdata,
  input  wire logic [7:0]           sfrRdata,
  // core register contents for the core
  output logic      [BANK_W-1:0]    bankSel,
  output logic      [7:0]           accumulator,
  output logic      [7:0]           flags,
  output logic      [7:0]           intControl
);

  // core registers
  logic [PC_W-1:0] pc_reg;
  logic [6:0]      pcHigh_reg;
  logic [7:0]      flags_reg;
  logic [15:0]     ptr0_reg;
  logic [15:0]     ptr1_reg;
  logic [4:0]      bankSel_reg;
  logic [7:0]      accum_reg;
  logic [7:0]      intCtl_reg;
  // read pipeline
  logic [7:0]      coreQ_reg;
  logic            fromRam_reg;
  logic            rvalid_reg;
  logic [PM_ADDR_W-1:0] pmPhys_reg;
  logic            pmHe_reg;
  // decode
  logic            isIndirect;
  logic [15:0]     ptrSel;
  logic [DATA_ADDR_W-1:0] effAddr;
  logic            effOk;
  logic [6:0]      effOff;
  logic [4:0]      effBank;
  bmmd_region_e    effRegion;
  logic            coreWr;
  logic            ramEn;
  logic [RAM_AW-1:0] ramAddr;
  logic [7:0]      ramQ;

  // indirect ports redirect through a pointer, else bank + offset
  always_comb begin
    isIndirect = (dataOffset == OFF_INDIRECT_DATA_PORT_0) ||
                 (dataOffset == OFF_INDIRECT_DATA_PORT_1);
    ptrSel     = dataOffset[0] ? ptr1_reg : ptr0_reg;
    if (isIndirect) begin
      effAddr = ptrSel[11:0];
      // pointer beyond the 12-bit data space, or back onto a port: nothing
      effOk   = (ptrSel[15:12] == 4'h0) && (ptrSel[6:1] != 6'h00);
    end else begin
      effAddr = {bankSel_reg, dataOffset};
      effOk   = 1'b1;
    end
    effOff    = effAddr[6:0];
    effBank   = effAddr[11:7];
    effRegion = bmmd_region(effOff);
  end

  // gpr bytes fold to bank*80 + offset - 0x20; common ignores the bank
  always_comb begin
    ramEn   = 1'b0;
    ramAddr = '0;
    if (dataReq && effOk) begin
      unique case (effRegion)
        RG_GPR: begin
          ramEn   = (effBank < GPR_BANKS);
          ramAddr = 10'(effBank * GPR_BYTES) + 10'(effOff - GPR_FIRST);
        end
        RG_COMMON: begin
          ramEn   = 1'b1;
          ramAddr = COMMON_BASE + 10'(effOff - COMMON_FIRST);
        end
        RG_CORE, RG_SFR: begin
          ramEn   = 1'b0;
        end
      endcase
    end
  end

  // sfr window is passed out with the full 12-bit address
  assign sfrReq   = dataReq && effOk && (effRegion == RG_SFR);
  assign sfrWe    = sfrReq && dataWe;
  assign sfrAddr  = effAddr;
  assign sfrWdata = dataWdata;
  assign coreWr   = dataReq && dataWe && effOk && (effRegion == RG_CORE);

  bmmd_ram u_ram (
    .clk_sys (clk_sys),
    .en      (ramEn),
    .we      (dataWe),
    .addr    (ramAddr),
    .wdata   (dataWdata),
    .rdata   (ramQ)
  );

  // program counter: interrupt beats a pc low write beats a jump beats a step
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      pc_reg <= RESET_VECTOR;
    end else if (intEntry) begin
      pc_reg <= INT_VECTOR;
    end else if (coreWr && effOff == OFF_PROGRAM_COUNTER_LOW) begin
      pc_reg <= {pcHigh_reg, dataWdata};
    end else if (pcLoad) begin
      pc_reg <= pcLoadValue;
    end else if (pcStep) begin
      pc_reg <= pc_reg + 15'h0001;
    end
  end

  // core register writes, same for every bank
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      pcHigh_reg  <= RST_PC_HIGH;
      flags_reg   <= RST_BYTE;
      ptr0_reg    <= {RST_BYTE, RST_BYTE};
      ptr1_reg    <= {RST_BYTE, RST_BYTE};
      bankSel_reg <= RST_BANK;
      accum_reg   <= RST_BYTE;
      intCtl_reg  <= RST_BYTE;
    end else if (coreWr) begin
      unique case (effOff)
        OFF_ARITH_AND_RESET_FLAGS: flags_reg       <= dataWdata;
        OFF_POINTER0_LOW:          ptr0_reg[7:0]   <= dataWdata;
        OFF_POINTER0_HIGH:         ptr0_reg[15:8]  <= dataWdata;
        OFF_POINTER1_LOW:          ptr1_reg[7:0]   <= dataWdata;
        OFF_POINTER1_HIGH:         ptr1_reg[15:8]  <= dataWdata;
        OFF_BANK_SELECTOR:         bankSel_reg     <= dataWdata[4:0];
        OFF_WORKING_ACCUMULATOR:   accum_reg       <= dataWdata;
        OFF_PC_HIGH_LATCH:         pcHigh_reg      <= dataWdata[6:0];
        OFF_INTERRUPT_CONTROL:     intCtl_reg      <= dataWdata;
        default: begin
        end
      endcase
    end
  end

  // read side: core and sfr values captured now, ram answers next cycle
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      coreQ_reg   <= RST_BYTE;
      fromRam_reg <= 1'b0;
      rvalid_reg  <= 1'b0;
    end else begin
      rvalid_reg  <= dataReq && !dataWe;
      fromRam_reg <= ramEn;
      coreQ_reg   <= RST_BYTE;
      if (dataReq && !dataWe && effOk) begin
        if (effRegion == RG_SFR) begin
          coreQ_reg <= sfrRdata;
        end else if (effRegion == RG_CORE) begin
          unique case (effOff)
            OFF_PROGRAM_COUNTER_LOW:   coreQ_reg <= pc_reg[7:0];
            OFF_ARITH_AND_RESET_FLAGS: coreQ_reg <= flags_reg;
            OFF_POINTER0_LOW:          coreQ_reg <= ptr0_reg[7:0];
            OFF_POINTER0_HIGH:         coreQ_reg <= ptr0_reg[15:8];
            OFF_POINTER1_LOW:          coreQ_reg <= ptr1_reg[7:0];
            OFF_POINTER1_HIGH:         coreQ_reg <= ptr1_reg[15:8];
            OFF_BANK_SELECTOR:         coreQ_reg <= {3'h0, bankSel_reg};
            OFF_WORKING_ACCUMULATOR:   coreQ_reg <= accum_reg;
            OFF_PC_HIGH_LATCH:         coreQ_reg <= {1'h0, pcHigh_reg};
            OFF_INTERRUPT_CONTROL:     coreQ_reg <= intCtl_reg;
            default:                   coreQ_reg <= RST_BYTE;
          endcase
        end
      end
    end
  end

  // program data reads wrap like fetches; result is held in flops
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      pmPhys_reg <= '0;
      pmHe_reg   <= 1'b0;
    end else if (pmReadReq) begin
      pmPhys_reg <= bmmd_wrap(pmReadAddr);
      pmHe_reg   <= bmmd_in_he(bmmd_wrap(pmReadAddr));
    end
  end

  // outputs; both read sources are flops, the mux picks one
  assign dataRdata     = fromRam_reg ? ramQ : coreQ_reg;
  assign dataRvalid    = rvalid_reg;
  assign pcValue       = pc_reg;
  assign fetchAddr     = bmmd_wrap(pc_reg);
  assign fetchHighEnd  = bmmd_in_he(bmmd_wrap(pc_reg));
  assign pmReadPhys    = pmPhys_reg;
  assign pmReadHighEnd = pmHe_reg;
  assign bankSel       = bankSel_reg;
  assign accumulator   = accum_reg;
  assign flags         = flags_reg;
  assign intControl    = intCtl_reg;

  // checks
  sequence sRead;
    dataReq && !dataWe;
  endsequence

  sequence sFarPtrRead;
    sRead ##0 (isIndirect && (ptrSel[15:12] != 4'h0));
  endsequence

  sequence sRdAcc;
    dataReq && !dataWe && (dataOffset == OFF_WORKING_ACCUMULATOR) && !coreWr;
  endsequence

  sequence sWrBank;
    dataReq && dataWe && (dataOffset == OFF_BANK_SELECTOR);
  endsequence

  chk_int_vector: assert property (@(posedge clk_sys) disable iff (!rst_b)
    intEntry |=> (pc_reg == INT_VECTOR))
    else $error("interrupt entry did not load vector");

  chk_pc_low_jump: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (coreWr && effOff == OFF_PROGRAM_COUNTER_LOW && !intEntry)
      |=> (pc_reg == {$past(pcHigh_reg), $past(dataWdata)}))
    else $error("pc low write did not form the jump target");

  chk_pm_wrap: assert property (@(posedge clk_sys) disable iff (!rst_b)
    pmReadReq |=> (pmReadPhys == $past(pmReadAddr[12:0])))
    else $error("program read address not wrapped");

  chk_he_window: assert property (@(posedge clk_sys) disable iff (!rst_b)
    pmReadReq |=> (pmReadHighEnd == ($past(pmReadAddr[12:7]) == 6'h3F)))
    else $error("high-endurance flag wrong");

  chk_bank_write: assert property (@(posedge clk_sys) disable iff (!rst_b)
    sWrBank |=> (bankSel == $past(dataWdata[4:0])))
    else $error("bank select not updated");

  chk_core_mirror: assert property (@(posedge clk_sys) disable iff (!rst_b)
    sRdAcc |=> dataRvalid ##0 (dataRdata == $past(accum_reg)))
    else $error("accumulator not mirrored in this bank");

  chk_direct_addr: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (sfrReq && !isIndirect) |-> (sfrAddr == {bankSel, dataOffset}))
    else $error("direct address not bank and offset");

  chk_unimpl_zero: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (dataReq && !dataWe && effRegion == RG_GPR && effBank >= GPR_BANKS)
      |=> (dataRvalid && dataRdata == 8'h00))
    else $error("unimplemented read not zero");

  chk_common_shared: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (ramEn && effRegion == RG_COMMON) |-> (ramAddr[9:4] == COMMON_BASE[9:4]))
    else $error("common byte not in shared storage");

  chk_read_answer: assert property (@(posedge clk_sys) disable iff (!rst_b)
    sRead |=> dataRvalid)
    else $error("read request got no valid pulse");

  chk_rvalid_pulse: assert property (@(posedge clk_sys) disable iff (!rst_b)
    dataRvalid |-> $past(dataReq && !dataWe))
    else $error("read valid without a read request");

  chk_pc_step: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (pcStep && !pcLoad && !intEntry && !coreWr)
      |=> (pcValue == $past(pcValue) + 15'h0001))
    else $error("program counter did not advance by one");

  chk_pc_load: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (pcLoad && !intEntry && !coreWr) |=> (pcValue == $past(pcLoadValue)))
    else $error("program counter did not take the jump target");

  chk_far_ptr_zero: assert property (@(posedge clk_sys) disable iff (!rst_b)
    sFarPtrRead |=> (dataRvalid && dataRdata == 8'h00))
    else $error("pointer past the data space did not read zero");

  chk_sfr_window: assert property (@(posedge clk_sys) disable iff (!rst_b)
    sfrReq |-> ((sfrAddr[6:0] >= SFR_FIRST) && (sfrAddr[6:0] < GPR_FIRST)))
    else $error("special-function request outside offsets 0C to 1F");

  chk_gpr_fold: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (ramEn && effRegion == RG_GPR) |-> (ramAddr < COMMON_BASE))
    else $error("general-purpose byte folded into common storage");

  chk_high_bank_ro: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (dataReq && dataWe && effRegion == RG_GPR && effBank >= GPR_BANKS) |-> !ramEn)
    else $error("write reached ram of an unimplemented bank");

  chk_core_local: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (dataReq && effOk && effRegion == RG_CORE) |-> (!ramEn && !sfrReq))
    else $error("core offset leaked to ram or special-function port");

  chk_pm_hold: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !pmReadReq |=> $stable(pmReadPhys))
    else $error("program read result not held");

  chk_fetch_he: assert property (@(posedge clk_sys) disable iff (!rst_b)
    fetchHighEnd |-> (fetchAddr >= HE_FLASH_BASE))
    else $error("fetch flagged high-endurance below the window");

endmodule

// ===== bmmd_pkg.sv
// bmmd_pkg: constants and types for the banked memory map decoder.
// assumes a single core clock; shared by the decoder and its ram.
package bmmd_pkg;

  // program side
  localparam int PC_W         = 15;         // full program counter width
  localparam int PM_ADDR_W    = 13;         // implemented space: 8,192 words
  localparam int PM_WORD_W    = 14;         // program word width
  localparam logic [14:0] RESET_VECTOR = 15'h0000;
  localparam logic [14:0] INT_VECTOR   = 15'h0004;
  localparam logic [12:0] HE_FLASH_BASE = 13'h1F80;  // top 128 words, low byte only
  localparam logic [12:0] HE_FLASH_LAST = 13'h1FFF;

  // data side
  localparam int DATA_ADDR_W  = 12;
  localparam int BANK_W       = 5;
  localparam int OFFS_W       = 7;
  localparam int NUM_BANKS    = 32;
  localparam int BANK_BYTES   = 128;
  localparam logic [6:0] SFR_FIRST    = 7'h0C;
  localparam logic [6:0] GPR_FIRST    = 7'h20;
  localparam logic [6:0] COMMON_FIRST = 7'h70;
  localparam logic [6:0] GPR_BYTES    = 7'h50;  // 80 bytes per bank
  localparam logic [4:0] GPR_BANKS    = 5'h0C;  // banks that carry ram
  localparam logic [9:0] COMMON_BASE  = 10'h3C0; // after 12 x 80 gpr bytes
  localparam int RAM_AW       = 10;

  // core register offsets, identical in every bank
  localparam logic [6:0] OFF_INDIRECT_DATA_PORT_0 = 7'h00;
  localparam logic [6:0] OFF_INDIRECT_DATA_PORT_1 = 7'h01;
  localparam logic [6:0] OFF_PROGRAM_COUNTER_LOW  = 7'h02;
  localparam logic [6:0] OFF_ARITH_AND_RESET_FLAGS = 7'h03;
  localparam logic [6:0] OFF_POINTER0_LOW         = 7'h04;
  localparam logic [6:0] OFF_POINTER0_HIGH        = 7'h05;
  localparam logic [6:0] OFF_POINTER1_LOW         = 7'h06;
  localparam logic [6:0] OFF_POINTER1_HIGH        = 7'h07;
  localparam logic [6:0] OFF_BANK_SELECTOR        = 7'h08;
  localparam logic [6:0] OFF_WORKING_ACCUMULATOR  = 7'h09;
  localparam logic [6:0] OFF_PC_HIGH_LATCH        = 7'h0A;
  localparam logic [6:0] OFF_INTERRUPT_CONTROL    = 7'h0B;

  // values after reset
  localparam logic [7:0] RST_BYTE    = 8'h00;
  localparam logic [4:0] RST_BANK    = 5'h00;
  localparam logic [6:0] RST_PC_HIGH = 7'h00;

  typedef enum logic [1:0] {
    RG_CORE   = 2'b00,
    RG_SFR    = 2'b01,
    RG_GPR    = 2'b10,
    RG_COMMON = 2'b11
  } bmmd_region_e;

  // which part of a bank an offset falls in
  function automatic bmmd_region_e bmmd_region(input logic [6:0] off);
    if (off < SFR_FIRST) begin
      return RG_CORE;
    end else if (off < GPR_FIRST) begin
      return RG_SFR;
    end else if (off < COMMON_FIRST) begin
      return RG_GPR;
    end
    return RG_COMMON;
  endfunction

  // fold any program address into the implemented space
  function automatic logic [12:0] bmmd_wrap(input logic [14:0] addr);
    return addr[12:0];
  endfunction

  // word lies in the high-endurance window
  function automatic logic bmmd_in_he(input logic [12:0] addr);
    return (addr >= HE_FLASH_BASE) && (addr <= HE_FLASH_LAST);
  endfunction

endpackage

// ===== bmmd_ram.sv
// bmmd_ram: byte-wide single-port ram for banked gpr and common bytes.
// assumes one access per cycle; read data appear one clock later.
`timescale 1ns/1ns
module bmmd_ram
  import bmmd_pkg::*;
(
  // clock
  input  wire logic              clk_sys,
  // access
  input  wire logic              en,
  input  wire logic              we,
  input  wire logic [RAM_AW-1:0] addr,
  input  wire logic [7:0]        wdata,
  output logic      [7:0]        rdata
);

  logic [7:0] mem [0:(1<<RAM_AW)-1];

  // no reset on the array: contents are undefined at power-up anyway
  always_ff @(posedge clk_sys) begin
    if (en && we) begin
      mem[addr] <= wdata;
    end
  end

  // registered read keeps the output a flop
  always_ff @(posedge clk_sys) begin
    if (en) begin
      rdata <= mem[addr];
    end
  end

endmodule

// ===== bmmd_sfr_model.sv
// bmmd_sfr_model: behavioural peripheral side of the sfr port.
// assumes the decoder drives the sfr signals combinationally off clk_sys.
`timescale 1ns/1ns
module bmmd_sfr_model
  import bmmd_pkg::*;
(
  // clock
  input  wire logic                   clk_sys,
  // sfr access
  input  wire logic                   sfrReq,
  input  wire logic                   sfrWe,
  input  wire logic [DATA_ADDR_W-1:0] sfrAddr,
  input  wire logic [7:0]             sfrWdata,
  output logic      [7:0]             sfrRdata
);
  logic [7:0] store [NUM_BANKS*32];
  logic [7:0] lastRd = 8'h00;
  // one byte per sfr slot of each bank; only offsets 0C-1F ever arrive
  always @(posedge clk_sys) begin
    if (sfrReq && sfrWe) begin
      store[{sfrAddr[11:7], sfrAddr[4:0]}] <= sfrWdata;
    end
    lastRd <= sfrRdata;
  end
  // unselected: inverse of last value, so stale data can never pass
  assign sfrRdata = sfrReq ? store[{sfrAddr[11:7], sfrAddr[4:0]}] : ~lastRd;
endmodule

// ===== tb_banked_memory_map_decoder.sv
// tb_banked_memory_map_decoder: self-checking bench for bmmd_decoder.
// assumes bmmd_pkg and bmmd_sfr_model are compiled before this file.
`timescale 1ns/1ns
module tb_banked_memory_map_decoder
  import bmmd_pkg::*;
;
  logic                   clk_sys, rst_b, pcStep, pcLoad, intEntry, pmReadReq;
  logic                   dataReq, dataWe, fetchHighEnd, pmReadHighEnd, dataRvalid;
  logic                   sfrReq, sfrWe;
  logic [PC_W-1:0]        pcLoadValue, pmReadAddr, pcValue;
  logic [PM_ADDR_W-1:0]   fetchAddr, pmReadPhys;
  logic [OFFS_W-1:0]      dataOffset;
  logic [7:0]             dataWdata, dataRdata, sfrWdata, sfrRdata;
  logic [7:0]             accumulator, flags, intControl;
  logic [DATA_ADDR_W-1:0] sfrAddr;
  logic [BANK_W-1:0]      bankSel;
  logic [7:0]             expQ [$];
  logic [31:0]            rv;
  integer                 seed;
  int                     miscompares, total_checks;

  bmmd_decoder dut (.clk_sys(clk_sys), .rst_b(rst_b), .pcStep(pcStep), .pcLoad(pcLoad),
    .pcLoadValue(pcLoadValue), .intEntry(intEntry), .pcValue(pcValue),
    .fetchAddr(fetchAddr), .fetchHighEnd(fetchHighEnd), .pmReadReq(pmReadReq),
    .pmReadAddr(pmReadAddr), .pmReadPhys(pmReadPhys), .pmReadHighEnd(pmReadHighEnd),
    .dataReq(dataReq), .dataWe(dataWe), .dataOffset(dataOffset), .dataWdata(dataWdata),
    .dataRdata(dataRdata), .dataRvalid(dataRvalid), .sfrReq(sfrReq), .sfrWe(sfrWe),
    .sfrAddr(sfrAddr), .sfrWdata(sfrWdata), .sfrRdata(sfrRdata), .bankSel(bankSel),
    .accumulator(accumulator), .flags(flags), .intControl(intControl));

  bmmd_sfr_model sfr (.clk_sys(clk_sys), .sfrReq(sfrReq), .sfrWe(sfrWe),
    .sfrAddr(sfrAddr), .sfrWdata(sfrWdata), .sfrRdata(sfrRdata));

  // 50 MHz core clock
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic give_verdict();
    $display("checks=%0d mismatches=%0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // one data access per falling edge; reads leave their expected byte queued
  task automatic acc(input logic w, input logic [6:0] o, input logic [7:0] d,
                     input logic [7:0] e);
    @(negedge clk_sys);
    dataReq    = 1'b1;
    dataWe     = w;
    dataOffset = o;
    dataWdata  = d;
    if (!w) begin
      expQ.push_back(e);
    end
  endtask

  task automatic setb(input logic [7:0] b);
    acc(1'b1, OFF_BANK_SELECTOR, b, 8'h00);
  endtask

  task automatic idle();
    @(negedge clk_sys);
    dataReq   = 1'b0;
    pcStep    = 1'b0;
    pcLoad    = 1'b0;
    intEntry  = 1'b0;
    pmReadReq = 1'b0;
  endtask

  // read data watcher: sampled mid-cycle, where the one-cycle pulse has settled
  always @(negedge clk_sys) begin
    if (dataRvalid === 1'b1) begin
      if (expQ.size() == 0) begin
        chk(16'(dataRdata), 16'hFFFF);
      end else begin
        chk(16'(dataRdata), 16'(expQ.pop_front()));
      end
    end
  end

  // hang guard, well above the length of the sequence
  initial begin
    #200000;
    miscompares++;
    give_verdict();
  end

  initial begin
    seed = 48746;
    miscompares = 0;
    total_checks = 0;
    {rst_b, pcStep, pcLoad, intEntry, pmReadReq, dataReq, dataWe} = '0;
    pcLoadValue = '0;
    pmReadAddr = '0;
    dataOffset = '0;
    dataWdata = '0;
    repeat (5) @(posedge clk_sys);
    @(negedge clk_sys);
    rst_b = 1'b1;
    chk(16'(pcValue), 16'h0000);
    // program counter: step, interrupt over step, wrap at the top
    pcStep = 1'b1;
    idle();
    chk(16'(pcValue), 16'h0001);
    pcStep = 1'b1;
    intEntry = 1'b1;
    idle();
    chk(16'(pcValue), 16'h0004);
    pcLoad = 1'b1;
    pcLoadValue = 15'h7FFF;
    @(negedge clk_sys);
    pcLoad = 1'b0;
    pcStep = 1'b1;
    idle();
    chk(16'(pcValue), 16'h0000);
    // fetch and program reads: window edges first, then random addresses
    for (int i = 0; i < 10; i++) begin
      rv = (i == 0) ? 32'h1F7F_3F80 : (i == 1) ? 32'h7FFF_5FFF : $random(seed);
      pcLoad = 1'b1;
      pcLoadValue = rv[14:0];
      pmReadReq = 1'b1;
      pmReadAddr = rv[30:16];
      idle();
      chk(16'(fetchAddr), 16'(rv[12:0]));
      chk(16'(fetchHighEnd), 16'(rv[12:7] == 6'h3F));
      chk(16'(pmReadPhys), 16'(rv[28:16]));
      chk(16'(pmReadHighEnd), 16'(rv[28:23] == 6'h3F));
    end
    $display("program side test done");
    // core registers written in bank 0, read back from bank 31
    setb(8'h00);
    acc(1'b1, OFF_ARITH_AND_RESET_FLAGS, 8'h5A, 8'h00);
    acc(1'b1, OFF_WORKING_ACCUMULATOR, 8'hC3, 8'h00);
    acc(1'b1, OFF_INTERRUPT_CONTROL, 8'h81, 8'h00);
    setb(8'h1F);
    acc(1'b0, OFF_ARITH_AND_RESET_FLAGS, 8'h00, 8'h5A);
    acc(1'b0, OFF_WORKING_ACCUMULATOR, 8'h00, 8'hC3);
    acc(1'b0, OFF_INTERRUPT_CONTROL, 8'h00, 8'h81);
    acc(1'b0, OFF_BANK_SELECTOR, 8'h00, 8'h1F);
    idle();
    chk(16'({flags, accumulator}), 16'h5AC3);
    chk(16'({intControl, 3'b000, bankSel}), 16'h811F);
    $display("core register test done");
    // banked ram, bank boundaries, unimplemented ram and common ram
    setb(8'h01);
    acc(1'b1, 7'h20, 8'h11, 8'h00);
    setb(8'h00);
    acc(1'b1, 7'h20, 8'h22, 8'h00);
    setb(8'h0B);
    acc(1'b1, 7'h6F, 8'h33, 8'h00);
    setb(8'h0C);
    acc(1'b1, 7'h20, 8'h44, 8'h00);
    acc(1'b0, 7'h20, 8'h00, 8'h00);
    setb(8'h0B);
    acc(1'b0, 7'h6F, 8'h00, 8'h33);
    setb(8'h01);
    acc(1'b0, 7'h20, 8'h00, 8'h11);
    setb(8'h00);
    acc(1'b0, 7'h20, 8'h00, 8'h22);
    setb(8'h03);
    acc(1'b1, 7'h7F, 8'h5E, 8'h00);
    setb(8'h07);
    acc(1'b0, 7'h7F, 8'h00, 8'h5E);
    $display("ram test done");
    // special-function slot in bank 2 goes out on the sfr port
    setb(8'h02);
    acc(1'b1, 7'h0C, 8'hA5, 8'h00);
    #1;
    chk(16'({sfrReq, sfrWe, 2'b00, sfrAddr}), 16'hC10C);
    chk(16'(sfrWdata), 16'h00A5);
    acc(1'b0, 7'h0C, 8'h00, 8'hA5);
    // both pointers: bank 1 ram, common ram, unimplemented ram
    acc(1'b1, OFF_POINTER0_LOW, 8'hA0, 8'h00);
    acc(1'b1, OFF_POINTER0_HIGH, 8'h00, 8'h00);
    acc(1'b0, OFF_INDIRECT_DATA_PORT_0, 8'h00, 8'h11);
    acc(1'b1, OFF_POINTER1_LOW, 8'h70, 8'h00);
    acc(1'b1, OFF_POINTER1_HIGH, 8'h01, 8'h00);
    acc(1'b1, OFF_INDIRECT_DATA_PORT_1, 8'h3C, 8'h00);
    acc(1'b0, 7'h70, 8'h00, 8'h3C);
    acc(1'b1, OFF_POINTER0_LOW, 8'h20, 8'h00);
    acc(1'b1, OFF_POINTER0_HIGH, 8'h06, 8'h00);
    acc(1'b0, OFF_INDIRECT_DATA_PORT_0, 8'h00, 8'h00);
    acc(1'b1, OFF_POINTER1_LOW, 8'h09, 8'h00);
    acc(1'b1, OFF_POINTER1_HIGH, 8'h00, 8'h00);
    acc(1'b0, OFF_INDIRECT_DATA_PORT_1, 8'h00, 8'hC3);
    acc(1'b1, OFF_POINTER1_HIGH, 8'h80, 8'h00);
    acc(1'b0, OFF_INDIRECT_DATA_PORT_1, 8'h00, 8'h00);
    $display("sfr and indirect test done");
    // writing the pc low byte jumps to the high latch and the written byte
    acc(1'b1, OFF_PC_HIGH_LATCH, 8'h15, 8'h00);
    acc(1'b1, OFF_PROGRAM_COUNTER_LOW, 8'h34, 8'h00);
    acc(1'b0, OFF_PROGRAM_COUNTER_LOW, 8'h00, 8'h34);
    acc(1'b0, OFF_PC_HIGH_LATCH, 8'h00, 8'h15);
    acc(1'b0, OFF_POINTER0_HIGH, 8'h00, 8'h06);
    acc(1'b0, OFF_POINTER1_HIGH, 8'h00, 8'h80);
    idle();
    chk(16'(pcValue), 16'h1534);
    $display("pc write test done");
    // let the last reads come back, within a bounded wait
    for (int i = 0; i < 20 && expQ.size() > 0; i++) begin
      @(negedge clk_sys);
    end
    if (expQ.size() > 0) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, expQ.size(), 0);
    end
    give_verdict();
  end
endmodule
